/* rst_map.vh */
// Constants for the reset initialization sequencer
// Behaviour
// - Primary clock is primary_clock_in in host mode, PCI bus clock in agent mode.
// - Device holds its own hard and soft reset outputs low at least 512 periods.
// - Soft reset output releases at least 16 sync periods after hard reset.
// - Config pins driven from 1 sync period after hard reset release, off at assertion; code drops them a few cycles late on an outside assertion.
// - Host mode sync period derives from primary clock via input_clock_divide_select.
// - DLL lock takes between 7680 and 122880 bus clock cycles, ratio dependent; code locks after a fixed DLL_LOCK_CYC sync cycles.
`ifndef RST_MAP_VH
`define RST_MAP_VH
`define RST_IN_MIN_CYC 32
`define RST_OUT_MIN_CYC 512
`define RST_SOFT_GAP_CYC 16
`define RST_CFG_ON_CYC 1
`define RST_STRAP_SETUP_CYC 4
`define RST_DLL_MIN_CYC 7680
`define RST_DLL_MAX_CYC 122880
`define RST_CNT_W 17
`define RST_BOOT_W 3
`define RST_BOOT_RESET 3'h0
`endif

/* rst_qual.v */
// Low-level qualifier: pulses once a synchronised active-low input has stayed low a minimum count
`timescale 1ns/1ps
`include "rst_map.vh"
module rst_qual #(
	parameter MIN_CYC = `RST_IN_MIN_CYC
) (
	input wire sys_clk_i, // System clock
	input wire resetn_i, // Synchronous reset, active low
	input wire pin_n_i, // Raw pin, active low
	output reg hit_o, // Pulse when low long enough
	output reg low_o // Synchronised level, active low asserted
);
	reg s1_q;
	reg s2_q;
	reg [6:0] cnt_q;
	always @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			cnt_q <= 7'h00;
			hit_o <= 1'b0;
			low_o <= 1'b1;
		end
		else
		begin
			s1_q <= pin_n_i;
			s2_q <= s1_q;
			low_o <= s2_q;
			hit_o <= 1'b0;
			if (s2_q)
				cnt_q <= 7'h00;
			else if (cnt_q < MIN_CYC[6:0])
			begin
				cnt_q <= cnt_q + 7'h01;
				if (cnt_q == MIN_CYC[6:0] - 7'h01)
					hit_o <= 1'b1;
			end
		end
	end
endmodule

/* rst_seq.v */
// Reset initialization sequencer top: qualifies inputs, latches straps, drives reset outputs
`timescale 1ns/1ps
`include "rst_map.vh"
module rst_seq #(
	parameter OUT_MIN_CYC = `RST_OUT_MIN_CYC,
	parameter DLL_LOCK_CYC = `RST_DLL_MIN_CYC
) (
	input wire sys_clk_i, // Sync clock, already selected by host/agent mode
	input wire resetn_i, // Synchronous reset, active low
	input wire agent_mode_i, // 1 = PCI agent, 0 = PCI host
	input wire power_on_reset_n_i, // Power-on reset pin, active low
	input wire hard_reset_n_i, // Hard reset open-drain pin input
	input wire soft_reset_n_i, // Soft reset open-drain pin input
	input wire [2:0] boot_source_select_i, // Boot source straps
	input wire input_clock_divide_select_i, // Clock divide strap
	output reg hard_reset_n_o, // Hard reset pin output level (always 0)
	output reg hard_reset_n_oe_o, // Hard reset pin drive enable
	output reg soft_reset_n_o, // Soft reset pin output level (always 0)
	output reg soft_reset_n_oe_o, // Soft reset pin drive enable
	output reg cfg_drive_o, // Device may drive config pins
	output reg [2:0] boot_source_o, // Latched boot source
	output reg clock_divide_o, // Latched clock divide
	output reg primary_clock_sel_o, // 1 = PCI bus clock as primary
	output reg dll_locked_o // DLL lock indication
);
	localparam ST_POR = 3'h0;
	localparam ST_HARD = 3'h1;
	localparam ST_GAP = 3'h2;
	localparam ST_RUN = 3'h3;
	localparam ST_SOFT = 3'h4;
	localparam integer GAP_CYC = `RST_SOFT_GAP_CYC;
	localparam [`RST_CNT_W-1:0] OUT_LIM = OUT_MIN_CYC[`RST_CNT_W-1:0];
	localparam [`RST_CNT_W-1:0] GAP_LIM = GAP_CYC[`RST_CNT_W-1:0];
	localparam [`RST_CNT_W-1:0] DLL_LIM = DLL_LOCK_CYC[`RST_CNT_W-1:0];
	wire por_hit;
	wire por_low;
	wire hrd_hit;
	wire hrd_low;
	wire sft_hit;
	wire sft_low;
	reg [2:0] st_q;
	reg [`RST_CNT_W-1:0] cnt_q;
	reg [`RST_CNT_W-1:0] dll_q;
	reg por_q;
	reg [2:0] boot_s1_q;
	reg [2:0] boot_s2_q;
	reg div_s1_q;
	reg div_s2_q;
	reg agent_s1_q;
	reg agent_s2_q;
	reg hoe_q;

	// True on the last cycle of a span of limit cycles counted from zero
	function at_limit;
		input [`RST_CNT_W-1:0] count;
		input [`RST_CNT_W-1:0] limit;
		begin
			// Same-width compare, no integer widening
			at_limit = (count >= limit - {{(`RST_CNT_W-1){1'b0}}, 1'b1});
		end
	endfunction

	// Power-on reset is taken from its level; the 32-cycle figure is the board's duty
	rst_qual #(.MIN_CYC(`RST_IN_MIN_CYC)) u_por (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.pin_n_i(power_on_reset_n_i),
		.hit_o(por_hit),
		.low_o(por_low)
	);
	rst_qual #(.MIN_CYC(`RST_IN_MIN_CYC)) u_hrd (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.pin_n_i(hard_reset_n_i),
		.hit_o(hrd_hit),
		.low_o(hrd_low)
	);
	rst_qual #(.MIN_CYC(`RST_IN_MIN_CYC)) u_sft (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.pin_n_i(soft_reset_n_i),
		.hit_o(sft_hit),
		.low_o(sft_low)
	);

	always @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			st_q <= ST_POR;
			cnt_q <= {`RST_CNT_W{1'b0}};
			dll_q <= {`RST_CNT_W{1'b0}};
			// Idle level of the pin, so no false release edge after reset
			por_q <= 1'b1;
			boot_s1_q <= 3'h0;
			boot_s2_q <= 3'h0;
			div_s1_q <= 1'b0;
			div_s2_q <= 1'b0;
			agent_s1_q <= 1'b0;
			agent_s2_q <= 1'b0;
			hoe_q <= 1'b1;
			boot_source_o <= `RST_BOOT_RESET;
			clock_divide_o <= 1'b0;
			primary_clock_sel_o <= 1'b0;
			dll_locked_o <= 1'b0;
		end
		else
		begin
			boot_s1_q <= boot_source_select_i;
			boot_s2_q <= boot_s1_q;
			div_s1_q <= input_clock_divide_select_i;
			div_s2_q <= div_s1_q;
			agent_s1_q <= agent_mode_i;
			agent_s2_q <= agent_s1_q;
			por_q <= por_low;
			// Straps sampled on the release edge of power-on reset
			if (!por_q && por_low)
			begin
				boot_source_o <= boot_s2_q;
				clock_divide_o <= div_s2_q;
				primary_clock_sel_o <= agent_s2_q;
			end
			if (cnt_q != {`RST_CNT_W{1'b1}})
				cnt_q <= cnt_q + 1'b1;
			if (!por_low)
			begin
				st_q <= ST_POR;
				cnt_q <= {`RST_CNT_W{1'b0}};
				hoe_q <= 1'b1;
				dll_q <= {`RST_CNT_W{1'b0}};
				dll_locked_o <= 1'b0;
			end
			else
			begin
				case (st_q)
					ST_POR:
					begin
						st_q <= ST_HARD;
						cnt_q <= {`RST_CNT_W{1'b0}};
					end
					ST_HARD:
						if (at_limit(cnt_q, OUT_LIM))
						begin
							hoe_q <= 1'b0;
							st_q <= ST_GAP;
							cnt_q <= {`RST_CNT_W{1'b0}};
						end
					ST_GAP:
						if (at_limit(cnt_q, GAP_LIM))
						begin
							st_q <= ST_RUN;
							dll_q <= {`RST_CNT_W{1'b0}};
						end
					ST_RUN:
					begin
						// Lock is modelled as a fixed count; real lock time varies with the clock ratio
						if (!dll_locked_o)
						begin
							dll_q <= dll_q + 1'b1;
							if (at_limit(dll_q, DLL_LIM))
								dll_locked_o <= 1'b1;
						end
						// A qualified hard request restarts the whole output sequence
						if (hrd_hit)
						begin
							st_q <= ST_HARD;
							hoe_q <= 1'b1;
							cnt_q <= {`RST_CNT_W{1'b0}};
							dll_locked_o <= 1'b0;
						end
						else if (sft_hit)
						begin
							st_q <= ST_SOFT;
							cnt_q <= {`RST_CNT_W{1'b0}};
						end
					end
					// Soft reset only: hard drive stays off unless a hard request arrives
					ST_SOFT:
						if (hrd_hit)
						begin
							st_q <= ST_HARD;
							hoe_q <= 1'b1;
							cnt_q <= {`RST_CNT_W{1'b0}};
							dll_locked_o <= 1'b0;
						end
						else if (at_limit(cnt_q, OUT_LIM))
							st_q <= ST_RUN;
					default:
						st_q <= ST_POR;
				endcase
			end
		end
	end

	// Pin drives kept apart from the sequence so every output is a plain flop
	always @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			hard_reset_n_o <= 1'b0;
			hard_reset_n_oe_o <= 1'b1;
			soft_reset_n_o <= 1'b0;
			soft_reset_n_oe_o <= 1'b1;
			cfg_drive_o <= 1'b0;
		end
		else
		begin
			// Open drain: level stays low, only the enables move
			hard_reset_n_o <= 1'b0;
			soft_reset_n_o <= 1'b0;
			hard_reset_n_oe_o <= hoe_q;
			soft_reset_n_oe_o <= (st_q != ST_RUN);
			// On one cycle after the hard drive is off; off with the restart of hard reset.
			// Pin path is synchronised, so an outside assertion is seen a few cycles late.
			cfg_drive_o <= !hard_reset_n_oe_o && !hoe_q && hrd_low && (st_q != ST_HARD);
		end
	end
endmodule

/* rst_board.sv */
// Board-side reset supervisor and strap model
`timescale 1ns/1ps
module rst_board (
	input wire clk_i, // Sync clock
	output reg por_n_o, // Power-on reset
	output reg hard_n_o, // Hard reset request
	output reg soft_n_o, // Soft reset request
	output reg [2:0] boot_o, // Boot straps
	output reg div_o, // Divide strap
	output reg agent_o // Mode strap
);
	initial {por_n_o, hard_n_o, soft_n_o, boot_o, div_o, agent_o} = 8'h60;
	task por(input [2:0] b, input d, input a);
	begin
		@(posedge clk_i) #1;
		por_n_o = 1'b0;
		{boot_o, div_o, agent_o} = {b, d, a};
		repeat (32) @(posedge clk_i);
		#1 por_n_o = 1'b1;
		fork
			begin
				repeat (4) @(posedge clk_i);
				// Flipped straps expose a late latch
				#1 {boot_o, div_o, agent_o} = ~{b, d, a};
			end
		join_none
	end
	endtask
	task pin(input h, input integer n);
	begin
		@(posedge clk_i) #1;
		if (h)
			hard_n_o = 1'b0;
		else
			soft_n_o = 1'b0;
		repeat (n) @(posedge clk_i);
		#1 {hard_n_o, soft_n_o} = 2'h3;
	end
	endtask
endmodule

/* rst_seq_chk.sv */
// Assertions on the reset sequencer outputs
`timescale 1ns/1ps
module rst_seq_chk #(parameter OUT_MIN_CYC = 512) (
	input wire sys_clk_i, // Clock
	input wire resetn_i, // Reset
	input wire hard_reset_n_oe_o, // Hard drive
	input wire soft_reset_n_oe_o, // Soft drive
	input wire cfg_drive_o // Config drive
);
	reg [15:0] hc_q;
	reg [7:0] gc_q;
	always @(posedge sys_clk_i)
		hc_q <= (!resetn_i || !hard_reset_n_oe_o) ? 16'h0 : hc_q + 16'h1;
	// Cycles since the hard drive went off, held at its top value
	always @(posedge sys_clk_i)
		gc_q <= (!resetn_i || hard_reset_n_oe_o) ? 8'h00 : ((gc_q == 8'hFF) ? gc_q : gc_q + 8'h01);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	// Counters trail the drive by one cycle, hence the one added
	chk_hard_long: assert property ($fell(hard_reset_n_oe_o) |-> hc_q + 16'h0001 >= OUT_MIN_CYC)
		else $error("hard reset drive too short");
	chk_soft_gap: assert property ($fell(soft_reset_n_oe_o) |-> !hard_reset_n_oe_o && gc_q >= 8'h0F)
		else $error("soft reset released too early");
	chk_soft_with_hard: assert property (hard_reset_n_oe_o |-> soft_reset_n_oe_o)
		else $error("soft reset off while hard reset driven");
	chk_cfg_after: assert property ($rose(cfg_drive_o) |-> !$past(hard_reset_n_oe_o))
		else $error("config drive before hard release");
	chk_cfg_off: assert property ($rose(hard_reset_n_oe_o) |-> !cfg_drive_o)
		else $error("config drive kept in hard reset");
	chk_cfg_idle: assert property (cfg_drive_o |-> !hard_reset_n_oe_o)
		else $error("config drive during hard reset");
	cover property ($fell(hard_reset_n_oe_o));
	cover property ($fell(soft_reset_n_oe_o));
	cover property ($rose(cfg_drive_o));
endmodule
bind rst_seq rst_seq_chk #(.OUT_MIN_CYC(OUT_MIN_CYC)) u_chk (.sys_clk_i, .resetn_i, .hard_reset_n_oe_o,
	.soft_reset_n_oe_o, .cfg_drive_o);

/* rst_seq_test.sv */
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; $display("ERROR %0t %h %h", $time, a, e); end end
module rst_seq_test;
	reg sys_clk_i = 1'b0;
	reg resetn_i = 1'b0;
	wire por_n, hr_n, sr_n, div, agent, hoe, soe, cfg, div_q, sel, dll, hr_lvl, sr_lvl;
	wire [2:0] boot, boot_q;
	integer errors = 0;
	integer cmp_count = 0;
	integer n;
	rst_board brd (.clk_i(sys_clk_i), .por_n_o(por_n), .hard_n_o(hr_n), .soft_n_o(sr_n), .boot_o(boot),
		.div_o(div), .agent_o(agent));
	rst_seq #(.DLL_LOCK_CYC(20)) dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .agent_mode_i(agent),
		.power_on_reset_n_i(por_n), .hard_reset_n_i(hr_n), .soft_reset_n_i(sr_n), .boot_source_select_i(boot),
		.input_clock_divide_select_i(div), .hard_reset_n_o(hr_lvl), .hard_reset_n_oe_o(hoe), .soft_reset_n_o(sr_lvl),
		.soft_reset_n_oe_o(soe), .cfg_drive_o(cfg), .boot_source_o(boot_q), .clock_divide_o(div_q),
		.primary_clock_sel_o(sel), .dll_locked_o(dll));
	initial forever #5 sys_clk_i = ~sys_clk_i;
	task final_report;
	begin
		if (errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	task cyc(input integer k);
	begin
		repeat (k) @(posedge sys_clk_i);
		#1;
	end
	endtask
	task wait_hard;
	begin
		n = 0;
		while (hoe !== 1'b0 && n < 2000)
		begin
			cyc(1);
			n++;
		end
	end
	endtask
	task por_run(input [2:0] b, input d, input a);
	begin
		brd.por(b, d, a);
		wait_hard;
		`CHK(n >= 512, 1'b1)
		`CHK({hr_lvl, sr_lvl}, 2'h0)
		cyc(15);
		`CHK({soe, cfg}, 2'h3)
		cyc(40);
		`CHK(soe, 1'b0)
		`CHK(boot_q, b)
		`CHK(div_q, d)
		`CHK(sel, a)
		`CHK(dll, 1'b1)
	end
	endtask
	task pulse_run;
	begin
		brd.pin(1'b1, 20);
		cyc(40);
		`CHK({hoe, cfg}, 2'h1)
		brd.pin(1'b1, 40);
		`CHK({hoe, cfg}, 2'h2)
		wait_hard;
		cyc(40);
		brd.pin(1'b0, 40);
		`CHK({hoe, soe}, 2'h1)
		`CHK({hr_lvl, sr_lvl}, 2'h0)
		cyc(600);
		`CHK(soe, 1'b0)
	end
	endtask
	initial
	begin
		cyc(10);
		resetn_i = 1'b1;
		por_run(3'h5, 1'b1, 1'b0);
		por_run(3'h2, 1'b0, 1'b1);
		pulse_run;
		final_report;
	end
	initial
	begin
		#60000;
		errors++;
		final_report;
	end
endmodule
